// >>> hdl/ddrct_top.sv
// ddr command timing controller: issues commands that honour module timing
// How it works
// (R1) a read or write to a bank waits at least 15 ns after that bank was activated.
// (R2) activates to different banks are at least 10 ns apart.
// (R3) a read waits at least 2 cycles after the last write data.
// (R4) refresh is scheduled on an average interval, 7812 ns floored to 390 cycles by default.
// (R5) no more than the max refresh gap passes between two refreshes.
// (R6) no more than eight refreshes are ever postponed.
// (R7) after self refresh exit only a read is held off past 75 ns; others wait 75 ns.
// (R8) after self refresh exit a read waits 200 cycles for the dll to relock.
// (R9) auto precharge accesses are issued only when row open time is already met.
// (R10) one strobe, MEM_DQS_OUT with MEM_DQS_OE, serves the whole data bus; there are no per-lane strobes.
// (R11) the write strobe is driven to a valid level by the write command cycle.
// (R12) a row stays open between 40 ns and 70000 ns.
// (R13) same-bank activates and activate to refresh are 55 ns apart.
// (R14) after a refresh only nop follows for 70 ns.
// (R15) clock enable stays high for the whole refresh busy time.
// (R16) every nanosecond minimum is rounded up to whole cycles.
// (R17) each of the four banks has its own timer.
`timescale 1ns/1ns
`include "ddrct_regs.svh"
module ddrct_top
   import ddrct_pkg::*;
#(
   parameter int NBANK      = 4,
   parameter int REFI_CYC   = `DDRCT_FLOOR(`DDRCT_REFI_NS),
   parameter int REFC_CYC   = `DDRCT_FLOOR(`DDRCT_REFC_NS),
   parameter int XSRD_CYC   = `DDRCT_XSRD_CK,
   parameter int BURST_CK   = 2
) (
   input  wire logic          CORE_CLK,
   input  wire logic          RST,
   input  wire logic          CE,
   input  wire logic          REQ_VALID,
   input  wire logic [2:0]    REQ_CMD,
   input  wire logic [1:0]    REQ_BANK,
   input  wire logic          REQ_AUTOPRE,
   output logic               REQ_READY,
   output logic [2:0]         MEM_CMD,
   output logic [1:0]         MEM_BANK,
   output logic               MEM_AUTOPRE,
   output logic               MEM_CKE,
   output logic               MEM_DQS_OUT,
   output logic               MEM_DQS_OE,
   output logic               REF_BUSY,
   output logic               SELF_ACTIVE
);
   localparam int RRD  = `DDRCT_CEIL(`DDRCT_RRD_NS);   // R16
   localparam int RFC  = `DDRCT_CEIL(`DDRCT_RFC_NS);   // R16
   localparam int XSNR = `DDRCT_CEIL(`DDRCT_XSNR_NS);  // R16
   localparam int RASN = `DDRCT_CEIL(`DDRCT_RAS_MIN_NS);
   localparam int RCD  = `DDRCT_CEIL(`DDRCT_RCD_NS);
   localparam int WTR  = `DDRCT_WTR_CK;
   localparam int PW   = 4;
   localparam int GW   = $clog2(REFC_CYC + 1);
   localparam int XW   = $clog2(XSRD_CYC + 1);

   function automatic logic is_access(input logic [2:0] c);
      is_access = (c == `DDRCT_CMD_RD) || (c == `DDRCT_CMD_WR);
   endfunction : is_access

   ddrct_state_t  st_q, st_d;
   logic [2:0]    cmd_q, cmd_d;
   logic [1:0]    bank_q, bank_d;
   logic          ap_q, ap_d, cke_q, cke_d, dqs_q, dqs_d, oe_q, oe_d, rdy_q, rdy_d;
   logic [3:0]    rrd_q, rrd_d, rfc_q, rfc_d, xsnr_q, xsnr_d;
   logic [3:0]    wtr_q, wtr_d;
   logic [XW-1:0] xsrd_q, xsrd_d;
   logic [GW-1:0] gap_q, gap_d, avg_q, avg_d;
   logic [PW-1:0] owe_q, owe_d;
   logic [NBANK-1:0] b_act, b_close, b_open, b_acc, b_actok, b_preok, b_must;
   logic          any_open, any_must, req_ok, want_ref, force_ref;
   logic          busy_q, busy_d, self_q, self_d;

   // one timer per bank
   genvar gi;
   generate
      for (gi = 0; gi < NBANK; gi++) begin : g_bank
         ddrct_bank u_bank (                            // R17
            .clk        (CORE_CLK),
            .rst        (RST),
            .ce         (CE),
            .act        (b_act[gi]),
            .close      (b_close[gi]),
            .open       (b_open[gi]),
            .access_ok  (b_acc[gi]),
            .act_ok     (b_actok[gi]),
            .pre_ok     (b_preok[gi]),
            .must_close (b_must[gi])
         );
         assign b_act[gi]   = CE && cmd_d == `DDRCT_CMD_ACT && bank_d == 2'(gi);
         assign b_close[gi] = CE && bank_d == 2'(gi) && (cmd_d == `DDRCT_CMD_PRE
                              || (is_access(cmd_d) && ap_d));
      end
   endgenerate

   // any_open feeds both the admission check and the scheduler; any_must feeds only the scheduler
   assign any_open  = |b_open;
   assign any_must  = |b_must;
   // refresh wanted when owed; forced near the hard gap or at the postpone limit
   assign want_ref  = owe_q != '0;
   assign force_ref = (owe_q >= PW'(`DDRCT_MAX_POSTPONE)) ||          // R6
                      (gap_q >= GW'(REFC_CYC - `DDRCT_FORCE_MARGIN));  // R5

   // admission check for the pending request
   always_comb begin
      req_ok = 1'b0;
      case (REQ_CMD)
         `DDRCT_CMD_NOP: req_ok = 1'b1;
         `DDRCT_CMD_ACT: req_ok = b_actok[REQ_BANK] && rrd_q == 4'h0   // R2 R13
                                  && !force_ref;
         `DDRCT_CMD_RD:  req_ok = b_acc[REQ_BANK] && wtr_q == 4'h0     // R1 R3
                                  && xsrd_q == '0                      // R8
                                  && (!REQ_AUTOPRE || b_preok[REQ_BANK]); // R9
         `DDRCT_CMD_WR:  req_ok = b_acc[REQ_BANK]                      // R1
                                  && (!REQ_AUTOPRE || b_preok[REQ_BANK]); // R9
         `DDRCT_CMD_PRE: req_ok = b_preok[REQ_BANK];                   // R12
         `DDRCT_CMD_REF: req_ok = !any_open && (&b_actok);             // R13
         `DDRCT_CMD_SRE: req_ok = !any_open && (&b_actok);
         default:        req_ok = 1'b0;
      endcase
   end

   // command scheduler next state
   always_comb begin
      st_d   = st_q;
      cmd_d  = `DDRCT_CMD_NOP;
      bank_d = bank_q;
      ap_d   = 1'b0;
      cke_d  = cke_q;
      rdy_d  = 1'b0;
      rrd_d  = (rrd_q != 4'h0) ? rrd_q - 4'h1 : rrd_q;
      rfc_d  = (rfc_q != 4'h0) ? rfc_q - 4'h1 : rfc_q;
      xsnr_d = (xsnr_q != 4'h0) ? xsnr_q - 4'h1 : xsnr_q;
      wtr_d  = (wtr_q != 4'h0) ? wtr_q - 4'h1 : wtr_q;
      xsrd_d = (xsrd_q != '0) ? xsrd_q - 1'b1 : xsrd_q;
      gap_d  = (gap_q != {GW{1'b1}}) ? gap_q + 1'b1 : gap_q;
      avg_d  = avg_q + 1'b1;
      owe_d  = owe_q;
      // average interval tick adds one owed refresh
      if (avg_q >= GW'(REFI_CYC - 1)) begin                        // R4
         avg_d = '0;
         if (owe_q != {PW{1'b1}})
            owe_d = owe_q + 1'b1;
      end
      case (st_q)
         DDRCT_IDLE: begin
            st_d = DDRCT_RUN;
         end
         DDRCT_SELF: begin
            // self refresh keeps rows alive; no owed count grows meanwhile
            owe_d = '0;
            gap_d = '0;
            cke_d = 1'b0;
            if (REQ_VALID && REQ_CMD == `DDRCT_CMD_SRX) begin
               st_d   = DDRCT_RUN;
               cke_d  = 1'b1;
               rdy_d  = 1'b1;
               cmd_d  = `DDRCT_CMD_SRX;
               xsnr_d = 4'(XSNR);                                    // R7
               xsrd_d = XW'(XSRD_CYC);                               // R8
            end
         end
         DDRCT_RUN: begin
            if (rfc_q != 4'h0 || xsnr_q != 4'h0) begin
               cke_d = 1'b1;                                         // R14 R15 R7
            end else if (want_ref && (force_ref || !REQ_VALID) && !any_open
                         && (&b_actok)) begin
               cmd_d = `DDRCT_CMD_REF;                               // R4 R13
               rfc_d = 4'(RFC);                                      // R14
               gap_d = '0;                                           // R5
               // start from owe_d so a tick landing in this cycle is not lost
               owe_d = owe_d - 1'b1;
            end else if (any_must) begin
               // a row close to its limit is closed before anything else
               for (int i = 0; i < NBANK; i++) begin
                  if (b_must[i] && cmd_d == `DDRCT_CMD_NOP) begin
                     cmd_d  = `DDRCT_CMD_PRE;                        // R12
                     bank_d = 2'(i);
                  end
               end
            end else if (force_ref && any_open) begin
               for (int i = 0; i < NBANK; i++) begin
                  if (b_preok[i] && cmd_d == `DDRCT_CMD_NOP) begin
                     cmd_d  = `DDRCT_CMD_PRE;
                     bank_d = 2'(i);
                  end
               end
            end else if (REQ_VALID && req_ok && !rdy_q) begin
               rdy_d  = 1'b1;
               cmd_d  = REQ_CMD;
               bank_d = REQ_BANK;
               ap_d   = REQ_AUTOPRE && is_access(REQ_CMD);
               if (REQ_CMD == `DDRCT_CMD_ACT)
                  rrd_d = 4'(RRD - 1);                               // R2
               if (REQ_CMD == `DDRCT_CMD_WR)
                  wtr_d = 4'(BURST_CK + WTR);                        // R3
               if (REQ_CMD == `DDRCT_CMD_REF) begin
                  rfc_d = 4'(RFC);                                   // R14
                  gap_d = '0;
                  if (owe_d != '0)
                     owe_d = owe_d - 1'b1;
               end
               if (REQ_CMD == `DDRCT_CMD_SRE) begin
                  st_d  = DDRCT_SELF;
                  cke_d = 1'b0;
               end
            end
         end
         default: st_d = DDRCT_IDLE;
      endcase
      // strobe driven low in the write cycle, then toggled through the burst
      oe_d  = (cmd_d == `DDRCT_CMD_WR) || (wtr_q > 4'(WTR));        // R11 R10
      dqs_d = (wtr_q > 4'(WTR)) ? ~dqs_q : 1'b0;
      // status flags get their own flops so no output is decoded logic
      busy_d = rfc_d != 4'h0;                                        // R15
      self_d = st_d == DDRCT_SELF;
   end

   // registers only
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_q   <= DDRCT_IDLE;
         cmd_q  <= `DDRCT_CMD_NOP;
         bank_q <= 2'h0;
         ap_q   <= 1'b0;
         cke_q  <= 1'b1;
         dqs_q  <= 1'b0;
         oe_q   <= 1'b0;
         rdy_q  <= 1'b0;
         rrd_q  <= 4'h0;
         rfc_q  <= 4'h0;
         xsnr_q <= 4'h0;
         wtr_q  <= 4'h0;
         xsrd_q <= '0;
         gap_q  <= '0;
         avg_q  <= '0;
         owe_q  <= '0;
         busy_q <= 1'b0;
         self_q <= 1'b0;
      end else if (CE) begin
         st_q   <= st_d;
         cmd_q  <= cmd_d;
         bank_q <= bank_d;
         ap_q   <= ap_d;
         cke_q  <= cke_d;
         dqs_q  <= dqs_d;
         oe_q   <= oe_d;
         rdy_q  <= rdy_d;
         rrd_q  <= rrd_d;
         rfc_q  <= rfc_d;
         xsnr_q <= xsnr_d;
         wtr_q  <= wtr_d;
         xsrd_q <= xsrd_d;
         gap_q  <= gap_d;
         avg_q  <= avg_d;
         owe_q  <= owe_d;
         busy_q <= busy_d;
         self_q <= self_d;
      end
   end

   // every output is a plain register copy
   assign REQ_READY   = rdy_q;
   assign MEM_CMD     = cmd_q;
   assign MEM_BANK    = bank_q;
   assign MEM_AUTOPRE = ap_q;
   assign MEM_CKE     = cke_q;
   assign MEM_DQS_OUT = dqs_q;
   assign MEM_DQS_OE  = oe_q;
   assign REF_BUSY    = busy_q;
   assign SELF_ACTIVE = self_q;
endmodule : ddrct_top

// >>> inc/ddrct_regs.svh
// timing constants for the ddr command timing controller
`ifndef DDRCT_REGS_SVH
`define DDRCT_REGS_SVH
`define DDRCT_CLK_PERIOD_NS    20
`define DDRCT_RCD_NS           15
`define DDRCT_RRD_NS           10
`define DDRCT_WTR_CK           2
`define DDRCT_RAS_MIN_NS       40
`define DDRCT_RAS_MAX_NS       70000
`define DDRCT_RC_NS            55
`define DDRCT_RFC_NS           70
`define DDRCT_RP_NS            15
`define DDRCT_XSNR_NS          75
`define DDRCT_XSRD_CK          200
`define DDRCT_REFI_NS          7812
`define DDRCT_REFC_NS          70300
`define DDRCT_MAX_POSTPONE     8
`define DDRCT_FORCE_MARGIN     16
`define DDRCT_CLOSE_MARGIN     4
`define DDRCT_CEIL(ns)         (((ns) + `DDRCT_CLK_PERIOD_NS - 1) / `DDRCT_CLK_PERIOD_NS)
`define DDRCT_FLOOR(ns)        ((ns) / `DDRCT_CLK_PERIOD_NS)
`define DDRCT_CMD_NOP          3'h0
`define DDRCT_CMD_ACT          3'h1
`define DDRCT_CMD_RD           3'h2
`define DDRCT_CMD_WR           3'h3
`define DDRCT_CMD_PRE          3'h4
`define DDRCT_CMD_REF          3'h5
`define DDRCT_CMD_SRE          3'h6
`define DDRCT_CMD_SRX          3'h7
`endif

// >>> inc/ddrct_pkg.sv
// types for the ddr command timing controller
package ddrct_pkg;
   typedef enum logic [1:0] {DDRCT_IDLE, DDRCT_SELF, DDRCT_RUN} ddrct_state_t;
endpackage : ddrct_pkg

// >>> hdl/ddrct_bank.sv
// per-bank timer: activate-to-access, same-bank cycle, row-open limits
`timescale 1ns/1ns
`include "ddrct_regs.svh"
module ddrct_bank
   import ddrct_pkg::*;
#(
   parameter int CW = 13
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          act,
   input  wire logic          close,
   output logic               open,
   output logic               access_ok,
   output logic               act_ok,
   output logic               pre_ok,
   output logic               must_close
);
   localparam int RCD  = `DDRCT_CEIL(`DDRCT_RCD_NS);
   localparam int RC   = `DDRCT_CEIL(`DDRCT_RC_NS);
   localparam int RASN = `DDRCT_CEIL(`DDRCT_RAS_MIN_NS);
   localparam int RASX = `DDRCT_FLOOR(`DDRCT_RAS_MAX_NS);
   localparam int RP   = `DDRCT_CEIL(`DDRCT_RP_NS);
   logic [CW-1:0] age_q, age_d;
   logic          open_q, open_d;
   logic [3:0]    rp_q, rp_d;
   // next state: age counts from activate, saturating
   always_comb begin
      open_d = open_q;
      age_d  = age_q;
      rp_d   = (rp_q != 4'h0) ? rp_q - 4'h1 : rp_q;
      if (act) begin
         open_d = 1'b1;
         age_d  = '0;
      end else begin
         if (close) begin
            open_d = 1'b0;
            rp_d   = 4'(RP);
         end
         if (age_q != {CW{1'b1}})
            age_d = age_q + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         open_q <= 1'b0;
         age_q  <= {CW{1'b1}};
         rp_q   <= 4'h0;
      end else if (ce) begin
         open_q <= open_d;
         age_q  <= age_d;
         rp_q   <= rp_d;
      end
   end
   assign open       = open_q;
   assign access_ok  = open_q && (age_q >= CW'(RCD - 1));          // R1
   assign act_ok     = !open_q && (age_q >= CW'(RC - 1)) && rp_q == 4'h0; // R13
   assign pre_ok     = open_q && (age_q >= CW'(RASN - 1));         // R12
   assign must_close = open_q && (age_q >= CW'(RASX - `DDRCT_CLOSE_MARGIN)); // R12
endmodule : ddrct_bank

// >>> sim/ddrct_top_asserts.sv
// concurrent checks on the controller command stream
`timescale 1ns/1ns
`include "ddrct_regs.svh"
module ddrct_top_asserts #(
   parameter int REFC_CYC = 100,
   parameter int XSRD_CYC = 200
) (
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic [2:0] MEM_CMD,
   input wire logic [1:0] MEM_BANK,
   input wire logic       MEM_CKE,
   input wire logic       MEM_DQS_OE,
   input wire logic       REF_BUSY,
   input wire logic       SELF_ACTIVE
);
   logic [11:0] ref_age_q, srx_age_q;
   logic        is_nop, is_act, is_rd, is_wr, is_pre, is_ref, is_srx;
   // command decode shared by the properties
   assign is_nop = MEM_CMD == `DDRCT_CMD_NOP;
   assign is_act = MEM_CMD == `DDRCT_CMD_ACT;
   assign is_rd  = MEM_CMD == `DDRCT_CMD_RD;
   assign is_wr  = MEM_CMD == `DDRCT_CMD_WR;
   assign is_pre = MEM_CMD == `DDRCT_CMD_PRE;
   assign is_ref = MEM_CMD == `DDRCT_CMD_REF;
   assign is_srx = MEM_CMD == `DDRCT_CMD_SRX;
   // saturating ages; self refresh stands in for refresh while it lasts
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ref_age_q <= 12'h000;
         srx_age_q <= 12'hfff;
      end else begin
         ref_age_q <= (is_ref || SELF_ACTIVE) ? 12'h000 : ref_age_q + 12'(ref_age_q != 12'hfff);
         srx_age_q <= is_srx ? 12'h000 : srx_age_q + 12'(srx_age_q != 12'hfff);
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_act_ref_gap: assert property (is_act |=> (!is_ref) [*2])
      else $error("refresh too soon after activate");
   a_ref_quiet: assert property (is_ref |=> is_nop [*3])
      else $error("command during refresh busy time");
   a_ref_cke: assert property (is_ref |-> MEM_CKE [*4])
      else $error("clock enable low during refresh");
   a_ref_busy_flag: assert property (is_ref |=> REF_BUSY [*2])
      else $error("refresh busy flag missing");
   a_wr_rd_gap: assert property (is_wr |=> (!is_rd) [*3])
      else $error("read too soon after write");
   a_srx_quiet: assert property (is_srx |=> is_nop [*3])
      else $error("command too soon after self refresh exit");
   a_srx_read: assert property (is_rd |-> srx_age_q >= 12'(XSRD_CYC - 1))
      else $error("read too soon after self refresh exit");
   a_ref_gap: assert property (ref_age_q < 12'(REFC_CYC))
      else $error("refresh gap too long");
   a_ras_min: assert property (is_act |=> !(is_pre && MEM_BANK == $past(MEM_BANK)))
      else $error("row closed too early");
   a_dqs_valid: assert property (is_wr |-> MEM_DQS_OE)
      else $error("write strobe not driven");
endmodule : ddrct_top_asserts
bind ddrct_top ddrct_top_asserts #(.REFC_CYC(REFC_CYC), .XSRD_CYC(XSRD_CYC)) u_ddrct_top_asserts (
   .CORE_CLK(CORE_CLK), .RST(RST), .MEM_CMD(MEM_CMD), .MEM_BANK(MEM_BANK), .MEM_CKE(MEM_CKE),
   .MEM_DQS_OE(MEM_DQS_OE), .REF_BUSY(REF_BUSY), .SELF_ACTIVE(SELF_ACTIVE));

// >>> sim/ddrct_mem_model.sv
// behavioural memory module: counts commands that break its timing
`timescale 1ns/1ns
`include "ddrct_regs.svh"
module ddrct_mem_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] cmd,
   input  wire logic [1:0] bank,
   input  wire logic       cke,
   input  wire logic       dqs_oe,
   output logic      [7:0] viol
);
   logic [11:0] act_age [4];
   logic [11:0] ref_age, wr_age, srx_age;
   logic        bad;
   function automatic logic [11:0] sat(input logic [11:0] a);
      return a + 12'(a != 12'hfff);
   endfunction : sat
   // each command is judged by the age of what it must trail; one strobe enable for the whole bus
   always_comb begin
      case (cmd)
         `DDRCT_CMD_ACT: bad = act_age[bank] < 12'h002 || ref_age < 12'h003
                               || srx_age < 12'h003;
         `DDRCT_CMD_RD:  bad = act_age[bank] == 12'hfff || wr_age < 12'h003
                               || srx_age < 12'h0c7;
         `DDRCT_CMD_WR:  bad = act_age[bank] == 12'hfff || !dqs_oe;
         `DDRCT_CMD_PRE: bad = act_age[bank] < 12'h001;
         `DDRCT_CMD_REF: bad = ref_age < 12'h003 || act_age[0] < 12'h002 || act_age[1] < 12'h002
                               || act_age[2] < 12'h002 || act_age[3] < 12'h002;
         default:        bad = 1'b0;
      endcase
      if ((cmd == `DDRCT_CMD_REF || ref_age < 12'h003) && !cke) bad = 1'b1;
   end
   // ages since each event; activate ages are kept one per bank so banks never share a timer
   always_ff @(posedge clk) begin
      if (rst) begin
         act_age <= '{4{12'hfff}};
         ref_age <= 12'hfff;
         wr_age  <= 12'hfff;
         srx_age <= 12'hfff;
         viol    <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++)
            act_age[i] <= (cmd == `DDRCT_CMD_ACT && bank == 2'(i)) ? 12'h000
                          : sat(act_age[i]);
         ref_age <= (cmd == `DDRCT_CMD_REF) ? 12'h000 : sat(ref_age);
         wr_age  <= (cmd == `DDRCT_CMD_WR) ? 12'h000 : sat(wr_age);
         srx_age <= (cmd == `DDRCT_CMD_SRX) ? 12'h000 : sat(srx_age);
         viol    <= viol + 8'(bad);
      end
   end
endmodule : ddrct_mem_model

// >>> sim/ddrct_top_tb.sv
// self-checking bench for the ddr command timing controller
`timescale 1ns/1ns
`include "ddrct_regs.svh"
module ddrct_top_tb;
   localparam int refi = 40;
   localparam int refc = 100;
   localparam logic [2:0] act = `DDRCT_CMD_ACT, rd = `DDRCT_CMD_RD, wr = `DDRCT_CMD_WR,
      pre = `DDRCT_CMD_PRE, sre = `DDRCT_CMD_SRE, srx = `DDRCT_CMD_SRX;
   logic       CORE_CLK, RST, CE, REQ_VALID, REQ_AUTOPRE, REQ_READY, MEM_AUTOPRE, MEM_CKE;
   logic       MEM_DQS_OUT, MEM_DQS_OE, REF_BUSY, SELF_ACTIVE;
   logic [2:0] REQ_CMD, MEM_CMD;
   logic [1:0] REQ_BANK, MEM_BANK;
   logic [7:0] viol;
   int         cyc, last_ref, n_ref, max_gap, errors, comparisons;
   ddrct_top #(.REFI_CYC(refi), .REFC_CYC(refc)) u_ddrct_top (.CORE_CLK(CORE_CLK), .RST(RST),
      .CE(CE), .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK),
      .REQ_AUTOPRE(REQ_AUTOPRE), .REQ_READY(REQ_READY), .MEM_CMD(MEM_CMD), .MEM_BANK(MEM_BANK),
      .MEM_AUTOPRE(MEM_AUTOPRE), .MEM_CKE(MEM_CKE), .MEM_DQS_OUT(MEM_DQS_OUT),
      .MEM_DQS_OE(MEM_DQS_OE), .REF_BUSY(REF_BUSY), .SELF_ACTIVE(SELF_ACTIVE));
   ddrct_mem_model u_ddrct_mem_model (.clk(CORE_CLK), .rst(RST), .cmd(MEM_CMD),
      .bank(MEM_BANK), .cke(MEM_CKE), .dqs_oe(MEM_DQS_OE), .viol(viol));
   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end
   // cycle count, hang guard and refresh statistics from the command stream
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
      if (!RST && MEM_CMD === `DDRCT_CMD_REF) begin
         n_ref <= n_ref + 1;
         last_ref <= cyc;
         if (cyc - last_ref > max_gap) max_gap <= cyc - last_ref;
      end
   end
   task automatic miss(input string what);
      errors++;
      $display("mismatch at %0t: %s", $time, what);
   endtask : miss
   task automatic chk_cmd(input logic [2:0] got, input logic [2:0] exp, input string what);
      comparisons++;
      if (got !== exp) miss(what);
   endtask : chk_cmd
   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) miss(what);
   endtask : chk_bit
   task automatic chk_ge(input int got, input int min, input string what);
      comparisons++;
      if (got < min) miss(what);
   endtask : chk_ge
   // request held through the edge at which ready is sampled high; outputs read settled
   task automatic send(input logic [2:0] c, input logic [1:0] b, input logic ap, output int t);
      int n;
      @(posedge CORE_CLK);
      #2;
      REQ_VALID = 1'b1;
      REQ_CMD = c;
      REQ_BANK = b;
      REQ_AUTOPRE = ap;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         #1;
         n++;
      end while (REQ_READY !== 1'b1 && n < 400);
      t = cyc;
      chk_bit(REQ_READY, 1'b1, "request not taken");
      chk_cmd(MEM_CMD, c, "issued command");
      chk_bit(MEM_AUTOPRE, ap, "auto precharge flag");
      if (c != sre && c != srx) chk_bit(MEM_BANK === b, 1'b1, "issued bank");
      @(posedge CORE_CLK);
      #2 REQ_VALID = 1'b0;
   endtask : send
   task automatic t_refresh();
      int n0;
      n0 = n_ref;
      repeat (400) @(posedge CORE_CLK);
      chk_ge(n_ref - n0, 400 / refi - `DDRCT_MAX_POSTPONE, "too few refreshes");
      chk_ge(refc, max_gap, "refresh gap too long");
   endtask : t_refresh
   task automatic t_access();
      int ta, tb, tr, tw, tp;
      send(act, 2'h0, 1'b0, ta);
      send(act, 2'h1, 1'b0, tb);
      chk_ge(tb - ta, 1, "activate spacing");
      send(rd, 2'h0, 1'b0, tr);
      chk_ge(tr - ta, 1, "activate to read");
      send(wr, 2'h1, 1'b0, tw);
      chk_bit(MEM_DQS_OUT, 1'b1, "write strobe not toggling");
      send(rd, 2'h1, 1'b0, tr);
      chk_ge(tr - tw, `DDRCT_WTR_CK + 2, "write to read");
      send(pre, 2'h0, 1'b0, tp);
      chk_ge(tp - ta, 2, "row open time");
      send(pre, 2'h1, 1'b0, tp);
      send(act, 2'h2, 1'b0, ta);
      send(rd, 2'h2, 1'b1, tr);
      chk_ge(tr - ta, `DDRCT_CEIL(`DDRCT_RAS_MIN_NS), "auto precharge too early");
   endtask : t_access
   // a frozen controller must not take a pending request
   task automatic t_freeze();
      int t;
      @(posedge CORE_CLK);
      #2;
      // freeze only on an idle slot, else the held command would repeat on the bus
      while (MEM_CMD !== `DDRCT_CMD_NOP) begin
         @(posedge CORE_CLK);
         #2;
      end
      CE = 1'b0;
      fork
         send(act, 2'h0, 1'b0, t);
         begin
            repeat (6) begin
               @(posedge CORE_CLK);
               #1 chk_bit(REQ_READY, 1'b0, "taken while frozen");
            end
            #1 CE = 1'b1;
         end
      join
      send(pre, 2'h0, 1'b0, t);
   endtask : t_freeze
   task automatic t_self();
      int t0, tx, ta, tr;
      send(sre, 2'h0, 1'b0, t0);
      repeat (10) @(posedge CORE_CLK);
      #1;
      chk_bit(SELF_ACTIVE, 1'b1, "not in self refresh");
      chk_bit(MEM_CKE, 1'b0, "clock enable high in self refresh");
      send(srx, 2'h0, 1'b0, tx);
      send(act, 2'h3, 1'b0, ta);
      chk_ge(ta - tx, 4, "exit to activate");
      // reopen late so a forced refresh cannot close the row under the waiting read
      send(pre, 2'h3, 1'b0, t0);
      repeat (160) @(posedge CORE_CLK);
      send(act, 2'h3, 1'b0, ta);
      send(rd, 2'h3, 1'b1, tr);
      chk_ge(tr - tx, 200, "exit to read");
      chk_bit(SELF_ACTIVE, 1'b0, "still in self refresh");
   endtask : t_self
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      RST = 1'b1;
      CE = 1'b1;
      REQ_VALID = 1'b0;
      REQ_CMD = 3'h0;
      REQ_BANK = 2'h0;
      REQ_AUTOPRE = 1'b0;
      repeat (3) @(posedge CORE_CLK);
      #2 RST = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      t_refresh();
      t_access();
      t_freeze();
      t_self();
      chk_bit(viol === 8'h00, 1'b1, "device saw a timing breach");
      print_verdict();
   end
endmodule : ddrct_top_tb
